/* verif/testbench.sv */
// Self-checking testbench for module stop control over AXI4-Lite
module testbench import stop_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals: instance 0 full variant, instance 1 small variant
  // ****************************************************************
  logic        clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [4:0]  idle;
  logic        aw_rdy [2], w_rdy [2], b_vld [2], ar_rdy [2], r_vld [2];
  logic [1:0]  b_resp [2], r_resp [2];
  logic [31:0] r_data [2], sa [2], sc [2];
  logic [4:0]  st_req [2], ck_en [2], mclk [2];
  logic [4:0]  pres [2] = '{5'b1_1111, 5'b1_0110};
  logic [31:0] amask [2] = '{32'h3000_0000, 32'h1000_0000};
  logic [31:0] cmask [2] = '{32'h0000_0085, 32'h0000_0081};
  int          bad_count, comparisons;

  // ****************************************************************
  // Design instances share every input
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_dut
    module_stop_control #(.PIN_COUNT(g ? 64 : 144), .RAM_KB(g ? 512 : 640)) module_stop_control_i (
      .clk_i(clk_i), .nrst_i(nrst_i),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(aw_rdy[g]), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(w_rdy[g]), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(b_vld[g]), .s_axi_bready_i(bready),
      .s_axi_bresp_o(b_resp[g]), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(ar_rdy[g]),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(r_vld[g]), .s_axi_rready_i(rready),
      .s_axi_rdata_o(r_data[g]), .s_axi_rresp_o(r_resp[g]), .mod_idle_i(idle),
      .mod_stop_req_o(st_req[g]), .mod_clk_en_o(ck_en[g]), .mod_clk_o(mclk[g]));
  end

  // Clock at 200 MHz
  always #2.5 clk_i = ~clk_i;

  // ****************************************************************
  // Expectation helpers
  // ****************************************************************
  function automatic logic [4:0] stop_vec(input logic [31:0] a, input logic [31:0] c);
    return {c[RAM_ZERO_STOP_POS], c[RAM_TWO_STOP_POS], c[STANDBY_STOP_POS],
            a[DMA_XFER_STOP_POS], a[EXT_DMA_STOP_POS]};
  endfunction : stop_vec

  // Cleared strobe lanes keep the old byte; absent bits stay zero
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = d[8*b +: 8];
    return o & m;
  endfunction : merge

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Bus tasks: payload held until its own ready, answer taken at its edge
  // ****************************************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    logic aw_p, w_p, done;
    int   n;
    aw_p = 1; w_p = 1; done = 0; n = 0; resp = 2'h3;
    @(posedge clk_i);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
    // No local limit: only the watchdog ends a wait that never gets an answer
    while (!done) begin
      @(posedge clk_i);
      n++;
      if (aw_p && aw_rdy[0]) begin aw_p = 0; awvalid <= 1'b0; end
      if (w_p && w_rdy[0]) begin w_p = 0; wvalid <= 1'b0; end
      if (b_vld[0]) begin done = 1; resp = b_resp[0]; bready <= 1'b0; end
    end
    // Taken at the first edge, answer raised at the second, seen at the third
    chk("write_cycles", 3, n);
    for (int i = 0; i < 2; i++) if (a == STOP_A_OFFSET) sa[i] = merge(sa[i], d, s, amask[i]);
    for (int i = 0; i < 2; i++) if (a == STOP_C_OFFSET) sc[i] = merge(sc[i], d, s, cmask[i]);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d0, output logic [31:0] d1,
                          output logic [1:0] resp);
    int   n;
    logic got;
    n = 0; got = 0; resp = 2'h3; d0 = 'x; d1 = 'x;
    @(posedge clk_i);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!got) begin
      @(posedge clk_i);
      n++;
      if (arvalid && ar_rdy[0]) arvalid <= 1'b0;
      if (r_vld[0]) begin got = 1; d0 = r_data[0]; d1 = r_data[1]; resp = r_resp[0]; end
    end
    rready <= 1'b0;
    // Taken at the first edge, data standing and seen at the second
    chk("read_cycles", 2, n);
  endtask : axi_read

  // Compare module outputs, register readback and gated clocks with the models
  task automatic check_all();
    logic [31:0] d0, d1;
    logic [1:0]  r;
    logic [4:0]  en [2];
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 2; i++) begin
      en[i] = ~stop_vec(sa[i], sc[i]) & pres[i];
      chk("stop_req", {27'h0, stop_vec(sa[i], sc[i])}, {27'h0, st_req[i]});
      chk("clk_en", {27'h0, en[i]}, {27'h0, ck_en[i]});
    end
    axi_read(STOP_A_OFFSET, d0, d1, r);
    chk("reg_a", sa[0], d0);
    chk("reg_a_small", sa[1], d1);
    chk("rresp_a", RESP_OKAY, r);
    axi_read(STOP_C_OFFSET, d0, d1, r);
    chk("reg_c", sc[0], d0);
    chk("reg_c_small", sc[1], d1);
    axi_read(STATUS_OFFSET, d0, d1, r);
    chk("status", {27'h0, en[0]}, d0);
    chk("status_small", {27'h0, en[1]}, d1);
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 2; i++) chk("gclk_high", {27'h0, en[i]}, {27'h0, mclk[i]});
    @(negedge clk_i);
    #1;
    for (int i = 0; i < 2; i++) chk("gclk_low", 0, {27'h0, mclk[i]});
  endtask : check_all

  task automatic do_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    sa = '{0, 0};
    sc = '{0, 0};
  endtask : do_reset

  // ****************************************************************
  // Watchdog: the tests take under a thousand cycles
  // ****************************************************************
  initial begin
    #100us;
    bad_count++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [1:0] r;
    logic [31:0] d0, d1;
    int k;
    clk_i = 0; nrst_i = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; idle = 5'h1F; bad_count = 0; comparisons = 0;
    sa = '{0, 0};
    sc = '{0, 0};
    void'($urandom(47997));
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    check_all();
    axi_write(STOP_A_OFFSET, 32'hFFFF_FFFF, 4'hF, r);
    axi_write(STOP_C_OFFSET, 32'hFFFF_FFFF, 4'hF, r);
    check_all();
    // Lanes holding the stop bits switched off: nothing changes
    axi_write(STOP_A_OFFSET, 32'h0000_0000, 4'h7, r);
    axi_write(STOP_C_OFFSET, 32'h0000_0000, 4'hE, r);
    check_all();
    for (int t = 0; t < 40; t++) begin
      axi_write(t[0] ? STOP_C_OFFSET : STOP_A_OFFSET, $urandom, 4'($urandom_range(15, 0)), r);
      chk("bresp", RESP_OKAY, r);
      check_all();
    end
    // Unmapped place and read-only status refuse without effect
    axi_read(12'h0FC, d0, d1, r);
    chk("unmapped_rdata", 0, d0);
    chk("unmapped_rresp", RESP_SLVERR, r);
    axi_write(12'h0FC, 32'hFFFF_FFFF, 4'hF, r);
    chk("unmapped_bresp", RESP_SLVERR, r);
    axi_write(STATUS_OFFSET, 32'h0000_0000, 4'hF, r);
    chk("status_bresp", RESP_SLVERR, r);
    axi_write(STOP_A_OFFSET, 0, 4'hF, r);
    axi_write(STOP_C_OFFSET, 0, 4'hF, r);
    check_all();
    // A busy module keeps its clock until it reports idle
    k = $urandom_range(4, 0);
    @(posedge clk_i);
    idle <= ~(5'h01 << k);
    axi_write(STOP_IN_C[k] ? STOP_C_OFFSET : STOP_A_OFFSET, 32'h1 << STOP_POS[k], 4'hF, r);
    repeat (3) @(posedge clk_i);
    chk("busy_stop_req", 1, {31'h0, st_req[0][k]});
    chk("busy_clk_en", 1, {31'h0, ck_en[0][k]});
    idle <= 5'h1F;
    check_all();
    // Reset in mid-run returns every module to running
    axi_write(STOP_A_OFFSET, 32'hFFFF_FFFF, 4'hF, r);
    axi_write(STOP_C_OFFSET, 32'hFFFF_FFFF, 4'hF, r);
    do_reset();
    check_all();
    report_and_stop();
  end
endmodule : testbench

/* verilog/clock_gate_cell.sv */
// Glitch-free clock gate for one stoppable module
module clock_gate_cell (
  // Clock and enable
  input  wire logic clk_i,
  input  wire logic en_i,
  // Gated clock
  output wire logic gclk_o
);

  logic en_latch;

  // Enable only changes while the clock is low, so no runt pulse escapes
  always_latch begin
    if (!clk_i) begin
      en_latch <= en_i;
    end
  end

  assign gclk_o = clk_i & en_latch;

endmodule : clock_gate_cell

/* verilog/module_stop_control.sv */
// Module stop control: AXI4-Lite stop registers and per-module clock gating
//
// Summary of operation
// [RULE1] After reset every module runs and every stop bit reads zero.
// [RULE2] Writing one to a stop bit moves that module into the stop state.
// [RULE3] Register A bit 29 stops external bus DMA, bit 28 the DMA/transfer unit.
// [RULE4] Register C bit 7 stops standby RAM, bit 2 RAM two, bit 0 RAM zero.
// [RULE5] RAM two stop control exists only on large RAM variants.
// [RULE6] External bus DMA stop control exists only on packages of enough pins.
// [RULE7] A stopped module draws less power than a running one.
// [RULE8] A set stop bit gates the module clock; clearing it restores the clock.
module module_stop_control
  import stop_ctrl_pkg::*;
#(
  parameter int PIN_COUNT = 144,
  parameter int RAM_KB    = 640
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // AXI4-Lite write address
  input  wire logic                   s_axi_awvalid_i,
  output wire logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic                   s_axi_wvalid_i,
  output wire logic                   s_axi_wready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  // AXI4-Lite write response
  output wire logic                   s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  output wire logic [1:0]             s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                   s_axi_arvalid_i,
  output wire logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr_i,
  // AXI4-Lite read data
  output wire logic                   s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  output wire logic [31:0]            s_axi_rdata_o,
  output wire logic [1:0]             s_axi_rresp_o,
  // Module side
  input  wire logic [NUM_MODULES-1:0] mod_idle_i,
  output wire logic [NUM_MODULES-1:0] mod_stop_req_o,
  output wire logic [NUM_MODULES-1:0] mod_clk_en_o,
  output wire logic [NUM_MODULES-1:0] mod_clk_o
);

  // ****************************************************************
  // Variant presence
  // ****************************************************************
  localparam logic HAS_EXT_DMA = (PIN_COUNT >= EXT_DMA_MIN_PINS); // RULE6
  localparam logic HAS_RAM_TWO = (RAM_KB >= RAM_TWO_MIN_KB);      // RULE5
  localparam logic [NUM_MODULES-1:0] PRESENT = {1'b1, HAS_RAM_TWO, 1'b1, 1'b1, HAS_EXT_DMA};

  // Refuse variants the map cannot describe
  if (PIN_COUNT < MIN_PINS || RAM_KB <= 0) begin : g_bad_variant
    $error("module_stop_control: unsupported PIN_COUNT or RAM_KB");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Low two address bits are ignored; every register is one aligned word
  function automatic reg_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[ADDR_W-1:2] == STOP_A_OFFSET[ADDR_W-1:2]) begin
      sel = SEL_STOP_A;
    end else if (addr[ADDR_W-1:2] == STOP_C_OFFSET[ADDR_W-1:2]) begin
      sel = SEL_STOP_C;
    end else if (addr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction : decode_addr

  // ****************************************************************
  // State
  // ****************************************************************
  logic                   aw_held_reg;
  logic [ADDR_W-1:0]      awaddr_reg;
  logic                   w_held_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic [NUM_MODULES-1:0] stop_bits_reg;
  logic [NUM_MODULES-1:0] stop_bits_next;
  logic [NUM_MODULES-1:0] clk_on_reg;
  logic [NUM_MODULES-1:0] clk_on_next;
  logic                   first_reg;

  // ****************************************************************
  // Handshake and select wires
  // ****************************************************************
  wire logic     aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire logic     w_take  = s_axi_wvalid_i & s_axi_wready_o;
  wire logic     ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire logic     wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire reg_sel_e wr_sel  = decode_addr(awaddr_reg);
  wire reg_sel_e rd_sel  = decode_addr(s_axi_araddr_i);

  // One write and one read in flight; ready drops while a request is held
  assign s_axi_awready_o = ~aw_held_reg;
  assign s_axi_wready_o  = ~w_held_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // ****************************************************************
  // Stop bit write decode
  // ****************************************************************
  // Absent modules keep a zero bit: writes to them are dropped
  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_stop_wr
    localparam int       POS  = STOP_POS[i];
    localparam reg_sel_e HOME = STOP_IN_C[i] ? SEL_STOP_C : SEL_STOP_A;
    wire logic hit = wr_fire & (wr_sel == HOME) & wstrb_reg[POS/8];
    assign stop_bits_next[i] = PRESENT[i] & (hit ? wdata_reg[POS] : stop_bits_reg[i]); // RULE2
  end

  // ****************************************************************
  // Read word assembly
  // ****************************************************************
  logic [31:0] word_a;
  logic [31:0] word_c;
  logic [31:0] word_status;
  logic [31:0] rd_word;

  // Reserved bits read zero; status shows which module clocks run
  always_comb begin
    word_a      = STOP_A_RESET;
    word_c      = STOP_C_RESET;
    word_status = 32'h0000_0000;
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (STOP_IN_C[i]) begin
        word_c[STOP_POS[i]] = stop_bits_reg[i]; // RULE4
      end else begin
        word_a[STOP_POS[i]] = stop_bits_reg[i]; // RULE3
      end
    end
    word_status[NUM_MODULES-1:0] = clk_on_reg;
  end

  assign rd_word = (rd_sel == SEL_STOP_A) ? word_a :
                   (rd_sel == SEL_STOP_C) ? word_c :
                   (rd_sel == SEL_STATUS) ? word_status : 32'h0000_0000;

  // ****************************************************************
  // Clock gate control
  // ****************************************************************
  // The clock is held until the module reports idle, so a stop never
  // cuts a transfer in half; restart follows one cycle after the bit clears
  assign clk_on_next = PRESENT & (~stop_bits_reg | (clk_on_reg & ~mod_idle_i)); // RULE8

  // ****************************************************************
  // Write channel registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses and the read-only status answer SLVERR
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_sel == SEL_STOP_A || wr_sel == SEL_STOP_C) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channel registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Stop bits and clock enables
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_bits_reg <= '0;      // RULE1
      clk_on_reg    <= PRESENT; // RULE1
      first_reg     <= 1'b1;
    end else begin
      stop_bits_reg <= stop_bits_next;
      clk_on_reg    <= clk_on_next;
      first_reg     <= 1'b0;
    end
  end

  assign mod_stop_req_o = stop_bits_reg;
  assign mod_clk_en_o   = clk_on_reg;

  // ****************************************************************
  // Clock gates
  // ****************************************************************
  // A gated module sees no clock edges, which is where the saving comes from
  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_gate
    clock_gate_cell u_gate (
      .clk_i  (clk_i),
      .en_i   (clk_on_reg[i]), // RULE7
      .gclk_o (mod_clk_o[i])
    );
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence write_word(reg_sel_e s, int lane);
    wr_fire && wr_sel == s && wstrb_reg[lane];
  endsequence

  sequence stop_settles(int m);
    stop_bits_reg[m] && mod_idle_i[m];
  endsequence

  reset_running_a: assert property ( // RULE1
    first_reg |-> stop_bits_reg == '0 && clk_on_reg == PRESENT && s_axi_rdata_o == '0)
    else $error("modules not all running after reset");

  ext_dma_bit_a: assert property ( // RULE3
    write_word(SEL_STOP_A, EXT_DMA_STOP_POS / 8) |=>
      stop_bits_reg[MOD_EXT_DMA] == (HAS_EXT_DMA & $past(wdata_reg[EXT_DMA_STOP_POS])))
    else $error("bit 29 of register A does not steer external bus DMA");

  dma_xfer_bit_a: assert property ( // RULE2
    write_word(SEL_STOP_A, DMA_XFER_STOP_POS / 8) |=>
      stop_bits_reg[MOD_DMA_XFER] == $past(wdata_reg[DMA_XFER_STOP_POS]))
    else $error("bit 28 of register A does not steer the DMA/transfer unit");

  standby_bit_a: assert property ( // RULE4
    write_word(SEL_STOP_C, STANDBY_STOP_POS / 8) |=>
      stop_bits_reg[MOD_STANDBY_RAM] == $past(wdata_reg[STANDBY_STOP_POS]) &&
      stop_bits_reg[MOD_RAM_ZERO] == $past(wdata_reg[RAM_ZERO_STOP_POS]))
    else $error("register C bits 7 or 0 do not steer standby RAM or RAM zero");

  ram_two_absent_a: assert property ( // RULE5
    !HAS_RAM_TWO |-> !stop_bits_reg[MOD_RAM_TWO] && !mod_clk_en_o[MOD_RAM_TWO])
    else $error("RAM two stop control active on a small RAM variant");

  ext_dma_absent_a: assert property ( // RULE6
    !HAS_EXT_DMA |-> !stop_bits_reg[MOD_EXT_DMA] && !mod_clk_en_o[MOD_EXT_DMA])
    else $error("external bus DMA stop control active on a small package");

  write_answer_a: assert property (
    wr_fire |=> s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
    else $error("write not answered one cycle after both halves held");

  read_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before it was taken");

  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_gate_chk
    gate_stop_a: assert property ( // RULE7
      stop_settles(i) |=> !mod_clk_en_o[i] [*2] or $fell(stop_bits_reg[i]))
      else $error("module clock still running after idle stop");
    gate_restart_a: assert property ( // RULE8
      PRESENT[i] && !stop_bits_reg[i] |=> mod_clk_en_o[i])
      else $error("module clock not restored after stop bit cleared");
  end

endmodule : module_stop_control

/* verilog/stop_ctrl_pkg.sv */
// Package: register map, bit layout and variant limits for module stop control
package stop_ctrl_pkg;

  // ****************************************************************
  // Register map (byte offsets, 4 KB window)
  // ****************************************************************
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] STOP_A_OFFSET   = 12'h000;
  localparam logic [11:0] STOP_C_OFFSET   = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;

  // ****************************************************************
  // Values after reset: every module running
  // ****************************************************************
  localparam logic [31:0] STOP_A_RESET    = 32'h0000_0000;
  localparam logic [31:0] STOP_C_RESET    = 32'h0000_0000;

  // ****************************************************************
  // Controlled modules and their stop bit positions
  // ****************************************************************
  localparam int NUM_MODULES       = 5;
  localparam int MOD_EXT_DMA       = 0;  // external_bus_dma
  localparam int MOD_DMA_XFER      = 1;  // dma_and_transfer_ctrl
  localparam int MOD_STANDBY_RAM   = 2;
  localparam int MOD_RAM_TWO       = 3;  // ram_block_two
  localparam int MOD_RAM_ZERO      = 4;  // ram_block_zero

  localparam int EXT_DMA_STOP_POS  = 29; // in stop_ctrl_reg_a
  localparam int DMA_XFER_STOP_POS = 28; // in stop_ctrl_reg_a
  localparam int STANDBY_STOP_POS  = 7;  // in stop_ctrl_reg_c
  localparam int RAM_TWO_STOP_POS  = 2;  // in stop_ctrl_reg_c
  localparam int RAM_ZERO_STOP_POS = 0;  // in stop_ctrl_reg_c

  localparam int STOP_POS  [NUM_MODULES] = '{EXT_DMA_STOP_POS, DMA_XFER_STOP_POS,
                                             STANDBY_STOP_POS, RAM_TWO_STOP_POS,
                                             RAM_ZERO_STOP_POS};
  localparam bit STOP_IN_C [NUM_MODULES] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  // ****************************************************************
  // Variant limits
  // ****************************************************************
  localparam int EXT_DMA_MIN_PINS = 100;
  localparam int RAM_TWO_MIN_KB   = 640;
  localparam int MIN_PINS         = 64;

  // ****************************************************************
  // Bus answers and register select
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_STOP_A = 2'b01,
    SEL_STOP_C = 2'b10,
    SEL_STATUS = 2'b11
  } reg_sel_e;

endpackage : stop_ctrl_pkg
